// file: hw/dtsc_top.sv
// diagnostic test-source configuration bank with its decoded controls
// assumes same-clock register master; gpio enables come from an outside domain,
// channel enables come from other register logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dtsc_top #(
    parameter int unsigned NCELL = 15,
    parameter int unsigned NAUX = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [dtsc_pkg::DTSC_AW-1:0] reg_addr,
    input wire logic [dtsc_pkg::DTSC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dtsc_pkg::DTSC_DW-1:0] reg_rdata,
    input wire logic [NCELL-1:0] cell_channel_enable,
    input wire logic [NCELL-1:0] cell_polarity,
    input wire logic [NAUX-1:0] pin_general_io_enable,
    output logic [NCELL-1:0] cell_current_source_on,
    output logic [NAUX-1:0] aux_current_source_on,
    output logic [NCELL-1:0] cell_measure_select,
    output logic adc_sequence_enable,
    output logic open_wire_threshold_select,
    output logic low_side_comp_only,
    output logic [NAUX-1:0] aux_discharge_on,
    output logic [NAUX-1:0] thermistor_bias_ground,
    output logic aux_mode_reserved,
    output dtsc_pkg::dtsc_cfg_t cfg
);
    import dtsc_pkg::*;

    // ----------------------------------------
    // register decode and storage
    // ----------------------------------------
    dtsc_req_t req;
    logic [15:0] cell_tsc_q;
    logic [15:0] aux_tsc_q;
    logic [15:0] gen_diag_q;
    logic we_cell;
    logic we_aux;
    logic we_gen;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign we_cell = req.wr && (req.addr == DTSC_CELL_TSC_OFF);
    assign we_aux = req.wr && (req.addr == DTSC_AUX_TSC_OFF);
    assign we_gen = req.wr && (req.addr == DTSC_GEN_DIAG_OFF);

    // masks drop writes to unused bits
    dtsc_reg16 #(.MASK(DTSC_CELL_TSC_MASK), .RST_VAL(DTSC_CELL_TSC_RST)) u_cell_tsc (
        .ref_clk(ref_clk),
        .rst(rst),
        .we(we_cell),
        .wdata(req.wdata),
        .q(cell_tsc_q)
    );

    dtsc_reg16 #(.MASK(DTSC_AUX_TSC_MASK), .RST_VAL(DTSC_AUX_TSC_RST)) u_aux_tsc (
        .ref_clk(ref_clk),
        .rst(rst),
        .we(we_aux),
        .wdata(req.wdata),
        .q(aux_tsc_q)
    );

    dtsc_reg16 #(.MASK(DTSC_GEN_DIAG_MASK), .RST_VAL(DTSC_GEN_DIAG_RST)) u_gen_diag (
        .ref_clk(ref_clk),
        .rst(rst),
        .we(we_gen),
        .wdata(req.wdata),
        .q(gen_diag_q)
    );

    // ----------------------------------------
    // read port, data one cycle after strobe
    // ----------------------------------------
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    always_comb begin
        rdata_next = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                DTSC_CELL_TSC_OFF: begin
                    rdata_next = cell_tsc_q;
                end
                DTSC_AUX_TSC_OFF: begin
                    rdata_next = aux_tsc_q;
                end
                DTSC_GEN_DIAG_OFF: begin
                    rdata_next = gen_diag_q;
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // synchronise pin enables from outside domain
    // ----------------------------------------
    logic [NAUX-1:0] gpio_s1_reg;
    logic [NAUX-1:0] gpio_s2_reg;
    logic [NAUX-1:0] gpio_s3_reg;
    logic [NAUX-1:0] gpio_reg;
    logic [NAUX-1:0] gpio_next;

    always_comb begin
        gpio_next = gpio_reg;
        for (int i = 0; i < NAUX; i++) begin
            if (gpio_s2_reg[i] == gpio_s3_reg[i]) begin
                gpio_next[i] = gpio_s3_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gpio_s1_reg <= '0;
            gpio_s2_reg <= '0;
            gpio_s3_reg <= '0;
            gpio_reg <= '0;
        end else begin
            gpio_s1_reg <= pin_general_io_enable;
            gpio_s2_reg <= gpio_s1_reg;
            gpio_s3_reg <= gpio_s2_reg;
            gpio_reg <= gpio_next;
        end
    end

    // ----------------------------------------
    // decoded diagnostic controls
    // ----------------------------------------
    dtsc_aux_mode_t aux_mode;
    logic open_mode;
    logic [NCELL-1:0] cell_src_next;
    logic [NAUX-1:0] aux_src_next;
    logic [NCELL-1:0] meas_next;
    logic [NAUX-1:0] disch_next;
    logic [NAUX-1:0] gnd_next;
    logic adc_next;
    logic opn_next;
    logic lso_next;
    logic rsvd_next;

    assign open_mode = cell_tsc_q[DTSC_OPEN_SEL_BIT];

    always_comb begin
        unique casez (gen_diag_q[DTSC_AUX_MODE_LSB +: 3])
            3'b00?: aux_mode = DTSC_AUX_NORMAL_M;
            DTSC_AUX_DISCHARGE: aux_mode = DTSC_AUX_DISCH_M;
            DTSC_AUX_THERM_GND: aux_mode = DTSC_AUX_GND_M;
            default: aux_mode = DTSC_AUX_RSVD_M;
        endcase
    end

    always_comb begin
        cell_src_next = cell_tsc_q[NCELL-1:0];
        aux_src_next = aux_tsc_q[NAUX-1:0] & ~gpio_reg;
        if (open_mode) begin
            meas_next = cell_channel_enable & ~cell_polarity;
        end else begin
            meas_next = cell_channel_enable;
        end
        adc_next = !open_mode;
        opn_next = open_mode;
        lso_next = open_mode;
        disch_next = '0;
        gnd_next = '0;
        rsvd_next = 1'b0;
        unique case (aux_mode)
            DTSC_AUX_NORMAL_M: begin
                disch_next = '0;
            end
            DTSC_AUX_DISCH_M: begin
                disch_next = ~gpio_reg;
            end
            DTSC_AUX_GND_M: begin
                gnd_next = ~gpio_reg;
            end
            DTSC_AUX_RSVD_M: begin
                rsvd_next = 1'b1;
            end
        endcase
    end

    logic [NCELL-1:0] cell_src_reg;
    logic [NAUX-1:0] aux_src_reg;
    logic [NCELL-1:0] meas_reg;
    logic [NAUX-1:0] disch_reg;
    logic [NAUX-1:0] gnd_reg;
    logic adc_reg;
    logic opn_reg;
    logic lso_reg;
    logic rsvd_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cell_src_reg <= '0;
            aux_src_reg <= '0;
            meas_reg <= '0;
            disch_reg <= '0;
            gnd_reg <= '0;
            adc_reg <= 1'b1;
            opn_reg <= 1'b0;
            lso_reg <= 1'b0;
            rsvd_reg <= 1'b0;
        end else begin
            cell_src_reg <= cell_src_next;
            aux_src_reg <= aux_src_next;
            meas_reg <= meas_next;
            disch_reg <= disch_next;
            gnd_reg <= gnd_next;
            adc_reg <= adc_next;
            opn_reg <= opn_next;
            lso_reg <= lso_next;
            rsvd_reg <= rsvd_next;
        end
    end

    assign cell_current_source_on = cell_src_reg;
    assign aux_current_source_on = aux_src_reg;
    assign cell_measure_select = meas_reg;
    assign adc_sequence_enable = adc_reg;
    assign open_wire_threshold_select = opn_reg;
    assign low_side_comp_only = lso_reg;
    assign aux_discharge_on = disch_reg;
    assign thermistor_bias_ground = gnd_reg;
    assign aux_mode_reserved = rsvd_reg;

    assign cfg.open_wire_mode = open_mode;
    assign cfg.cell_src_en = cell_tsc_q[14:0];
    assign cfg.aux_src_en = aux_tsc_q[5:0];
    assign cfg.aux_mode = gen_diag_q[DTSC_AUX_MODE_LSB +: 3];
endmodule
`default_nettype wire

// file: hw/dtsc_pkg.sv
// package for the diagnostic test-source configuration bank
// assumes a 16-bit register port with 8-bit word addresses
package dtsc_pkg;
    localparam int unsigned DTSC_AW = 8;
    localparam int unsigned DTSC_DW = 16;
    localparam int unsigned DTSC_NCELL = 15;
    localparam int unsigned DTSC_NAUX = 6;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] DTSC_CELL_TSC_OFF = 8'h6c;
    localparam logic [7:0] DTSC_AUX_TSC_OFF = 8'h6d;
    localparam logic [7:0] DTSC_GEN_DIAG_OFF = 8'h6e;

    // ----------------------------------------
    // field positions, masks and resets
    // ----------------------------------------
    localparam int unsigned DTSC_OPEN_SEL_BIT = 15;
    localparam int unsigned DTSC_AUX_MODE_LSB = 13;
    localparam logic [15:0] DTSC_CELL_TSC_MASK = 16'hffff;
    localparam logic [15:0] DTSC_AUX_TSC_MASK = 16'h003f;
    localparam logic [15:0] DTSC_GEN_DIAG_MASK = 16'he000;
    localparam logic [15:0] DTSC_CELL_TSC_RST = 16'h0000;
    localparam logic [15:0] DTSC_AUX_TSC_RST = 16'h0000;
    localparam logic [15:0] DTSC_GEN_DIAG_RST = 16'h0000;

    // ----------------------------------------
    // aux diagnostic mode codes
    // ----------------------------------------
    localparam logic [2:0] DTSC_AUX_DISCHARGE = 3'h2;
    localparam logic [2:0] DTSC_AUX_THERM_GND = 3'h3;

    typedef enum logic [3:0] {
        DTSC_AUX_NORMAL_M = 4'h1,
        DTSC_AUX_DISCH_M = 4'h2,
        DTSC_AUX_GND_M = 4'h4,
        DTSC_AUX_RSVD_M = 4'h8
    } dtsc_aux_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dtsc_req_t;

    typedef struct packed {
        logic open_wire_mode;
        logic [14:0] cell_src_en;
        logic [5:0] aux_src_en;
        logic [2:0] aux_mode;
    } dtsc_cfg_t;
endpackage

// file: hw/dtsc_reg16.sv
// one masked 16-bit configuration register
// assumes write strobe is a single-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dtsc_reg16 #(
    parameter logic [15:0] MASK = 16'hffff,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [15:0] wdata,
    output logic [15:0] q
);
    logic [15:0] q_reg;
    logic [15:0] q_next;

    always_comb begin
        q_next = q_reg;
        if (we) begin
            q_next = wdata & MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

// file: verification/dtsc_top_sva.sv
// checker for the dtsc_top register bank ports
// assumes a single ref_clk domain, rst async high
`timescale 1ns/1ps
`default_nettype none
module dtsc_top_sva
    import dtsc_pkg::*;
#(
    parameter int unsigned NCELL = 15,
    parameter int unsigned NAUX = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DTSC_AW-1:0] reg_addr,
    input wire logic [DTSC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DTSC_DW-1:0] reg_rdata,
    input wire logic [NCELL-1:0] cell_channel_enable,
    input wire logic [NCELL-1:0] cell_polarity,
    input wire logic [NAUX-1:0] pin_general_io_enable,
    input wire logic [NCELL-1:0] cell_current_source_on,
    input wire logic [NAUX-1:0] aux_current_source_on,
    input wire logic [NCELL-1:0] cell_measure_select,
    input wire logic adc_sequence_enable,
    input wire logic open_wire_threshold_select,
    input wire logic low_side_comp_only,
    input wire logic [NAUX-1:0] aux_discharge_on,
    input wire logic [NAUX-1:0] thermistor_bias_ground,
    input wire logic aux_mode_reserved,
    input wire dtsc_cfg_t cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic cw;
    assign cw = reg_wr && reg_addr == DTSC_CELL_TSC_OFF;
    // ----------------------------------------
    // assertions and covers
    // ----------------------------------------
    cell_src_write_a: assert property (cw ##1 !cw |=>
        cell_current_source_on == $past(reg_wdata[NCELL-1:0], 2)) else $error("cell source");
    open_mode_a: assert property (low_side_comp_only == $past(cfg.open_wire_mode)
        && open_wire_threshold_select == $past(cfg.open_wire_mode)) else $error("open mode");
    adc_seq_a: assert property (adc_sequence_enable != $past(cfg.open_wire_mode)) else $error("adc seq");
    measure_sel_a: assert property (!$past(rst) |-> cell_measure_select == ($past(cfg.open_wire_mode) ?
        $past(cell_channel_enable & ~cell_polarity) : $past(cell_channel_enable))) else $error("measure");
    aux_src_gate_a: assert property ((aux_current_source_on & ~$past(cfg.aux_src_en)) == '0)
        else $error("aux source");
    // pin seen five edges back once two samples agree
    aux_gpio_gate_a: assert property ($past(pin_general_io_enable, 4) == $past(pin_general_io_enable, 5) |->
        (aux_current_source_on & $past(pin_general_io_enable, 5)) == '0) else $error("gpio gate");
    aux_disch_a: assert property ($past(cfg.aux_mode) != DTSC_AUX_DISCHARGE |->
        aux_discharge_on == '0) else $error("discharge");
    therm_gnd_a: assert property ($past(cfg.aux_mode) != DTSC_AUX_THERM_GND |->
        thermistor_bias_ground == '0) else $error("therm gnd");
    mode_rsvd_a: assert property (aux_mode_reserved == $past(cfg.aux_mode[2])) else $error("reserved");
    rdata_idle_a: assert property (reg_rdata != '0 |-> $past(reg_rd)) else $error("rdata idle");
    aux_rd_mask_a: assert property (reg_rd && reg_addr == DTSC_AUX_TSC_OFF |=>
        reg_rdata[15:6] == '0) else $error("aux mask");
    cover property (cw ##1 !cw);
    cover property (low_side_comp_only);
    cover property (aux_discharge_on != '0);
endmodule
bind dtsc_top dtsc_top_sva #(.NCELL(NCELL), .NAUX(NAUX)) i_sva (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cell_channel_enable(cell_channel_enable), .cell_polarity(cell_polarity),
    .pin_general_io_enable(pin_general_io_enable),
    .cell_current_source_on(cell_current_source_on), .aux_current_source_on(aux_current_source_on),
    .cell_measure_select(cell_measure_select), .adc_sequence_enable(adc_sequence_enable),
    .open_wire_threshold_select(open_wire_threshold_select), .low_side_comp_only(low_side_comp_only),
    .aux_discharge_on(aux_discharge_on), .thermistor_bias_ground(thermistor_bias_ground),
    .aux_mode_reserved(aux_mode_reserved), .cfg(cfg));
`default_nettype wire

// file: verification/dtsc_host.sv
// host model: register master on the bank's plain port
// assumes callers enter the tasks between clock edges
`timescale 1ns/1ps
`default_nettype none
module dtsc_host (
    input wire logic ref_clk,
    output logic [dtsc_pkg::DTSC_AW-1:0] reg_addr,
    output logic [dtsc_pkg::DTSC_DW-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [dtsc_pkg::DTSC_DW-1:0] reg_rdata
);
    import dtsc_pkg::*;
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write, returns on the edge decoded outputs land
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
        @(posedge ref_clk);
    endtask
    // data taken only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: verification/dtsc_top_test.sv
// self-checking bench for dtsc_top
// assumes dtsc_host as register master, checker bound separately
`timescale 1ns/1ps
`default_nettype none
module dtsc_top_test;
    import dtsc_pkg::*;
    logic ref_clk, rst, reg_wr, reg_rd, adc, thr, low, rsv;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [14:0] en, pol, csrc, meas;
    logic [5:0] gpio, asrc, dis, gnd;
    dtsc_cfg_t cfg;
    int n_mismatch = 0;
    int checks_done = 0;
    dtsc_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_channel_enable(en),
        .cell_polarity(pol), .pin_general_io_enable(gpio), .cell_current_source_on(csrc),
        .aux_current_source_on(asrc), .cell_measure_select(meas), .adc_sequence_enable(adc),
        .open_wire_threshold_select(thr), .low_side_comp_only(low), .aux_discharge_on(dis),
        .thermistor_bias_ground(gnd), .aux_mode_reserved(rsv), .cfg(cfg));
    dtsc_host i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        i_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        rst <= 1'b1;
        en <= '0;
        pol <= '0;
        gpio <= '0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk({13'h0, thr, low, adc}, 16'h0001);
        rchk(DTSC_CELL_TSC_OFF, 16'h0000);
        rchk(DTSC_AUX_TSC_OFF, 16'h0000);
        rchk(DTSC_GEN_DIAG_OFF, 16'h0000);
        @(posedge ref_clk);
        en <= 15'h7fff;
        pol <= 15'h0f0f;
        i_host.wr(DTSC_CELL_TSC_OFF, 16'hffff);
        #1 chk({1'b0, csrc}, 16'h7fff);
        chk({1'b0, meas}, 16'h70f0);
        chk({13'h0, thr, low, adc}, 16'h0006);
        chk({cfg.open_wire_mode, cfg.cell_src_en}, 16'hffff);
        rchk(DTSC_CELL_TSC_OFF, 16'hffff);
        i_host.wr(DTSC_CELL_TSC_OFF, 16'h0005);
        #1 chk({1'b0, meas}, 16'h7fff);
        chk({13'h0, thr, low, adc}, 16'h0001);
        // pulldowns on measured channels in open mode
        i_host.wr(DTSC_CELL_TSC_OFF, 16'hf0f0);
        #1 chk({1'b0, csrc}, 16'h70f0);
        i_host.wr(DTSC_AUX_TSC_OFF, 16'hffff);
        rchk(DTSC_AUX_TSC_OFF, 16'h003f);
        @(posedge ref_clk);
        gpio <= 6'h05;
        repeat (6) @(posedge ref_clk);
        #1 chk({10'h0, asrc}, 16'h003a);
        rchk(DTSC_AUX_TSC_OFF, 16'h003f);
        // every aux mode code, all eight with open mode set
        for (int c = 0; c < 8; c++) begin
            i_host.wr(DTSC_GEN_DIAG_OFF, {c[2:0], 13'h1fff});
            #1 chk({3'h0, dis, gnd, rsv}, {3'h0, (c == 2) ? 6'h3a : 6'h0, (c == 3) ? 6'h3a : 6'h0, c[2]});
        end
        chk({7'h0, cfg.aux_mode, cfg.aux_src_en}, 16'h01ff);
        rchk(DTSC_GEN_DIAG_OFF, 16'he000);
        i_host.wr(8'h6f, 16'hffff);
        rchk(8'h6f, 16'h0000);
        rchk(DTSC_CELL_TSC_OFF, 16'hf0f0);
        final_report();
    end
endmodule
`default_nettype wire
